// >>> verilog/sbl_pkg.sv
/*
 serial boot loader package: constants, states and carriers.
 assumes a single 40 MHz clock domain.
*/
package sbl_pkg;
   // clock rate in hz
   localparam int unsigned SBL_CLK_HZ = 40000000;
   // acknowledge byte returned after baud detection
   localparam logic [7:0] SBL_ACK_BYTE = 8'h55;
   // ram window for loaded code
   localparam logic [19:0] SBL_RAM_FIRST = 20'h0fa40;
   localparam logic [19:0] SBL_RAM_LAST = 20'h0fa5f;
   // number of loaded bytes
   localparam int unsigned SBL_LOAD_BYTES = 32;
   // zero byte spans start plus eight data bits
   localparam int unsigned SBL_ZERO_BITS = 9;
   // width of the baud counters
   localparam int unsigned SBL_CNT_W = 24;
   // line level constants and the four-bit data bit count
   localparam logic SBL_LINE_IDLE = 1'b1;
   localparam logic SBL_LINE_START = 1'b0;
   localparam logic [3:0] SBL_DATA_BITS = 4'h8;

   // boot loader sequence states
   typedef enum logic [2:0] {
      SBL_IDLE,
      SBL_WAIT_ZERO,
      SBL_MEASURE,
      SBL_WAIT_STOP,
      SBL_SEND_ACK,
      SBL_LOAD,
      SBL_RUN
   } sbl_state_e;

   // ram write carrier
   typedef struct packed {
      logic [19:0] addr;
      logic [7:0] data;
   } sbl_ramwr_s;
endpackage : sbl_pkg

// >>> verilog/sbl_buf2.sv
/*
 two-entry buffer with valid/ready on both sides.
 assumes one clock and asynchronous active-high reset.
*/
`timescale 1ns/10ps
module sbl_buf2 #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [WIDTH-1:0] mem [2]; // storage
   logic wr_ptr; // write slot
   logic rd_ptr; // read slot
   logic [1:0] count; // entries held
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // full stops the source, so a stall loses nothing
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];

   ////////////////////////////////////////////////////////////////////////
   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : sbl_buf2

// >>> verilog/sbl_loader.sv
/*
 serial boot loader: strap entry, zero-byte baud measurement, ack
 transmit, 32-byte ram load and jump.
 assumes rxd and strap pins are asynchronous; ram sink is on clk.
*/
`timescale 1ns/10ps
module sbl_loader
   import sbl_pkg::*;
#(
   parameter int unsigned CNT_W = SBL_CNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sw_reset,
   input wire logic ale_pin,
   input wire logic nmi_n_pin,
   input wire logic bus_mode_select_0,
   input wire logic bus_mode_select_1,
   input wire logic bus_active_select_n,
   input wire logic serial0_receive_line,
   output logic serial0_transmit_line,
   output logic boot_loader_mode,
   output logic [CNT_W-1:0] baud_period,
   output logic baud_valid,
   output sbl_ramwr_s ram_wr,
   output logic ram_wr_en,
   input wire logic ram_wr_ready,
   output logic jump_req,
   output logic [19:0] jump_addr
);
   // synchronisers, first stage read only by second
   logic [1:0] rx_sync;
   logic [1:0] ale_sync;
   logic [1:0] nmi_sync;
   logic rxd; // synchronised receive line
   logic rst_seen; // high for the first cycle after release
   logic ale_latched; // ale value caught at reset end

   sbl_state_e state; // sequence state
   logic [CNT_W-1:0] cnt; // bit and measurement timer
   logic [CNT_W-1:0] bit_t; // measured bit period
   logic [3:0] bit_idx; // bit within frame
   logic [7:0] shreg; // rx shift register
   logic [9:0] txreg; // tx frame shifter
   logic [5:0] byte_cnt; // loaded bytes
   logic [19:0] addr; // next ram address
   logic rx_push; // byte ready for buffer
   logic buf_in_ready;
   logic [7:0] buf_data;
   logic buf_valid;
   logic [CNT_W-1:0] next_bit_t;
   logic [CNT_W-1:0] bit_end; // last count of one bit time
   logic [CNT_W-1:0] slot_end; // last count of the current rx slot
   logic wr_free; // ram port can take a new byte this cycle

   // divide a 9-bit measurement down to one bit
   function automatic logic [CNT_W-1:0] div9(input logic [CNT_W-1:0] v);
      div9 = v / CNT_W'(SBL_ZERO_BITS);
   endfunction : div9

   assign rxd = rx_sync[1];
   assign next_bit_t = div9(cnt);
   assign bit_end = bit_t - CNT_W'(1);
   // start slot waits half a bit so data is sampled near mid-bit
   assign slot_end = (bit_idx == 4'h0) ? (bit_t >> 1) : bit_end;
   // a held write frees the port only when the sink takes it
   assign wr_free = !ram_wr_en || ram_wr_ready;

   ////////////////////////////////////////////////////////////////////////
   // receive line synchroniser, parked idle during reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_sync <= {2{SBL_LINE_IDLE}};
      end else begin
         rx_sync <= {rx_sync[0], serial0_receive_line};
      end
   end

   // strap synchronisers run through reset, so the first edges after
   // release see the pin levels rather than a reset value
   always_ff @(posedge clk) begin
      ale_sync <= {ale_sync[0], ale_pin};
      nmi_sync <= {nmi_sync[0], nmi_n_pin};
   end

   // strap capture just after reset release; bus mode pins unused
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_seen <= 1'b1;
         ale_latched <= 1'b0;
      end else begin
         rst_seen <= 1'b0;
         if (rst_seen) ale_latched <= ale_sync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= SBL_IDLE;
         cnt <= '0;
         bit_t <= '0;
         bit_idx <= 4'h0;
         shreg <= 8'h0;
         txreg <= '1;
         rx_push <= 1'b0;
         boot_loader_mode <= 1'b0;
         baud_valid <= 1'b0;
         baud_period <= '0;
      end else if (sw_reset) begin
         // software reset ignores the strap and drops the mode
         state <= SBL_RUN;
         boot_loader_mode <= 1'b0;
         rx_push <= 1'b0;
         txreg <= '1;
      end else begin
         rx_push <= 1'b0;
         unique case (state)
            SBL_IDLE: begin
               // entry needs ale strap and nmi active right after reset
               if (!rst_seen) begin
                  if (ale_latched && !nmi_sync[1]) begin
                     state <= SBL_WAIT_ZERO;
                     boot_loader_mode <= 1'b1;
                  end else begin
                     state <= SBL_RUN;
                  end
               end
            end
            SBL_WAIT_ZERO: begin
               // a falling edge starts the zero byte
               // the edge that sees the start counts as the first cycle
               cnt <= CNT_W'(1);
               if (rxd == SBL_LINE_START) state <= SBL_MEASURE;
            end
            SBL_MEASURE: begin
               // line stays low for start plus eight zero bits
               cnt <= cnt + CNT_W'(1);
               if (rxd == SBL_LINE_IDLE) begin
                  if (next_bit_t != '0) begin
                     bit_t <= next_bit_t;
                     baud_period <= next_bit_t;
                     baud_valid <= 1'b1;
                     txreg <= {SBL_LINE_IDLE, SBL_ACK_BYTE,
                               SBL_LINE_START};
                     bit_idx <= 4'h0;
                     cnt <= '0;
                     state <= SBL_SEND_ACK;
                  end else begin
                     // glitch too short: back to waiting
                     state <= SBL_WAIT_ZERO;
                  end
               end
            end
            SBL_SEND_ACK: begin
               // shift ack out lsb first, ten bit times
               if (cnt >= bit_t - CNT_W'(1)) begin
                  cnt <= '0;
                  txreg <= {SBL_LINE_IDLE, txreg[9:1]};
                  bit_idx <= bit_idx + 4'h1;
                  if (bit_idx == SBL_DATA_BITS + 4'h1) begin
                     state <= SBL_WAIT_STOP;
                  end
               end else begin
                  cnt <= cnt + CNT_W'(1);
               end
            end
            SBL_WAIT_STOP: begin
               // hunt next start bit; held while buffer is full
               cnt <= '0;
               bit_idx <= 4'h0;
               if (byte_cnt == 6'(SBL_LOAD_BYTES)) begin
                  // window full: control passes to the loaded code
                  state <= SBL_RUN;
               end else if (rxd == SBL_LINE_START && buf_in_ready) begin
                  state <= SBL_LOAD;
               end
            end
            SBL_LOAD: begin
               // sample at mid-bit, lsb first; one stop bit suffices
               if (cnt >= slot_end) begin
                  cnt <= '0;
                  bit_idx <= bit_idx + 4'h1;
                  if (bit_idx == 4'h0) begin
                     if (rxd != SBL_LINE_START) state <= SBL_WAIT_STOP;
                  end else if (bit_idx <= SBL_DATA_BITS) begin
                     shreg <= {rxd, shreg[7:1]};
                  end else begin
                     // stop slot: 9th bits or 2nd stop are idle-high
                     rx_push <= 1'b1;
                     state <= SBL_WAIT_STOP;
                  end
               end else begin
                  cnt <= cnt + CNT_W'(1);
               end
            end
            SBL_RUN: begin
               // loaded code executes from ram window
            end
            default: state <= SBL_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // byte buffer between receiver and ram port
   sbl_buf2 #(
      .WIDTH(8)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .in_data(shreg),
      .in_valid(rx_push),
      .in_ready(buf_in_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(wr_free)
   );

   // ram writes in arrival order, then jump; a stalled write is held
   // with its address and data until the sink takes it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ram_wr <= '0;
         ram_wr_en <= 1'b0;
         byte_cnt <= 6'h0;
         addr <= SBL_RAM_FIRST;
         jump_addr <= SBL_RAM_FIRST;
         jump_req <= 1'b0;
         serial0_transmit_line <= SBL_LINE_IDLE;
      end else begin
         serial0_transmit_line <= txreg[0];
         jump_req <= 1'b0;
         if (wr_free) begin
            ram_wr_en <= 1'b0;
            // bytes beyond the window are popped and dropped
            if (buf_valid && byte_cnt < 6'(SBL_LOAD_BYTES)) begin
               ram_wr <= '{addr: addr, data: buf_data};
               ram_wr_en <= 1'b1;
               addr <= addr + 20'h1;
               byte_cnt <= byte_cnt + 6'h1;
            end
         end
         // jump to window start once the last byte is taken
         if (ram_wr_en && ram_wr_ready && ram_wr.addr == SBL_RAM_LAST) begin
            jump_req <= 1'b1;
            jump_addr <= SBL_RAM_FIRST;
         end
      end
   end
endmodule : sbl_loader

// >>> sim/sbl_loader_monitor.sv
/*
 checker on the loader's ports, bound into sbl_loader.
 assumes one clock and rst asynchronous, active high.
*/
`timescale 1ns/10ps
module sbl_loader_monitor
   import sbl_pkg::*;
#(
   parameter int unsigned CNT_W = SBL_CNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sw_reset,
   input wire logic serial0_transmit_line,
   input wire logic boot_loader_mode,
   input wire logic [CNT_W-1:0] baud_period,
   input wire logic baud_valid,
   input wire sbl_ramwr_s ram_wr,
   input wire logic ram_wr_en,
   input wire logic ram_wr_ready,
   input wire logic jump_req,
   input wire logic [19:0] jump_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // address the sink should see next
   logic [19:0] next_addr;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         next_addr <= SBL_RAM_FIRST;
      end else if (ram_wr_en && ram_wr_ready) begin
         next_addr <= ram_wr.addr + 20'h00001;
      end
   end
   // a write taken, and the final one of the window
   sequence s_take;
      ram_wr_en && ram_wr_ready;
   endsequence
   sequence s_last;
      s_take ##0 ram_wr.addr == SBL_RAM_LAST;
   endsequence
   ////////////////////////////////////////
   AST_ADDR_ORDER: assert property (
      s_take |-> ram_wr.addr == next_addr) else $error("write out of order");
   AST_ADDR_WINDOW: assert property (
      ram_wr_en |-> ram_wr.addr inside {[SBL_RAM_FIRST:SBL_RAM_LAST]})
      else $error("write outside window");
   AST_JUMP_LAST: assert property (
      s_last |=> jump_req) else $error("no jump after last byte");
   AST_JUMP_TARGET: assert property (
      jump_req |-> jump_addr == SBL_RAM_FIRST) else $error("bad jump target");
   AST_JUMP_PULSE: assert property (
      jump_req |=> !jump_req) else $error("jump longer than a cycle");
   AST_WR_IN_MODE: assert property (
      ram_wr_en |-> boot_loader_mode && baud_valid)
      else $error("write outside loader mode");
   AST_TX_QUIET: assert property (
      !baud_valid |-> serial0_transmit_line) else $error("tx before baud");
   AST_BAUD_HOLD: assert property (
      baud_valid ##1 baud_valid |-> $stable(baud_period))
      else $error("bit period moved");
   AST_SWRST_EXIT: assert property (
      sw_reset |-> ##[1:2] !boot_loader_mode) else $error("mode kept");
endmodule : sbl_loader_monitor

bind sbl_loader sbl_loader_monitor #(.CNT_W(CNT_W)) u_sbl_loader_monitor (
   .clk(clk), .rst(rst), .sw_reset(sw_reset),
   .serial0_transmit_line(serial0_transmit_line),
   .boot_loader_mode(boot_loader_mode), .baud_period(baud_period),
   .baud_valid(baud_valid), .ram_wr(ram_wr), .ram_wr_en(ram_wr_en),
   .ram_wr_ready(ram_wr_ready), .jump_req(jump_req), .jump_addr(jump_addr));

// >>> sim/sbl_host.sv
/*
 host on the serial side: frames, glitches and ack capture.
 assumes the bench calls its tasks; line idles high.
*/
`timescale 1ns/10ps
module sbl_host #(
   parameter int BIT = 16
) (
   input wire logic clk,
   output logic rxd,
   input wire logic txd
);
   initial rxd = 1'b1;
   // start, eight data lsb first, one or two stop bits
   task automatic send(input logic [7:0] b, input int stops);
      logic [10:0] f;
      f = {2'b11, b, 1'b0};
      for (int i = 0; i < 9 + stops; i++) begin
         @(posedge clk) rxd <= f[i];
         repeat (BIT - 1) @(posedge clk);
      end
   endtask : send
   // short low pulse, too short to be a zero byte
   task automatic glitch(input int len);
      @(posedge clk) rxd <= 1'b0;
      repeat (len) @(posedge clk);
      rxd <= 1'b1;
   endtask : glitch
   // mid-bit sampling; bounded hunt for the start bit
   task automatic recv(output logic [7:0] b, output bit ok);
      int n;
      n = 0;
      ok = 0;
      b = 8'h00;
      while (txd !== 1'b0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      if (n < 4000) begin
         ok = 1;
         repeat (BIT / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = txd;
         end
      end
   endtask : recv
endmodule : sbl_host

// >>> sim/test_sbl_loader.sv
/*
 bench: strap entry, baud detect, ack, 32-byte load, exit.
 assumes sbl_host on the serial side and a stalling ram sink.
*/
`timescale 1ns/10ps
module test_sbl_loader;
   import sbl_pkg::*;
   localparam int BIT = 16; // host bit time in clocks
   logic clk, rst, sw_reset, ale_pin, nmi_n_pin, rxd, txd, mode;
   logic bus_mode_select_0, bus_mode_select_1, bus_active_select_n;
   logic baud_valid, ram_wr_en, jump_req, ok;
   logic ram_wr_ready = 1'b1; // driven only by the sink process
   logic [SBL_CNT_W-1:0] baud_period;
   logic [19:0] jump_addr;
   logic [7:0] ack;
   sbl_ramwr_s ram_wr;
   sbl_ramwr_s rows [32]; // data sent beside the write expected
   sbl_ramwr_s got [$]; // writes the sink took
   int mismatches, checked, n;
   int jumps = 0; // owned by the sink process
   int cyc = 0; // owned by the sink process
   sbl_loader u_sbl_loader (.clk(clk), .rst(rst), .sw_reset(sw_reset),
      .ale_pin(ale_pin), .nmi_n_pin(nmi_n_pin),
      .bus_mode_select_0(bus_mode_select_0),
      .bus_mode_select_1(bus_mode_select_1),
      .bus_active_select_n(bus_active_select_n),
      .serial0_receive_line(rxd), .serial0_transmit_line(txd),
      .boot_loader_mode(mode), .baud_period(baud_period),
      .baud_valid(baud_valid), .ram_wr(ram_wr), .ram_wr_en(ram_wr_en),
      .ram_wr_ready(ram_wr_ready), .jump_req(jump_req),
      .jump_addr(jump_addr));
   sbl_host #(.BIT(BIT)) u_sbl_host (.clk(clk), .rxd(rxd), .txd(txd));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // sink stalls one cycle in eight for the first half of the load
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ram_wr_ready <= got.size() >= 16 || cyc[2:0] != 3'h0;
      if (ram_wr_en && ram_wr_ready) got.push_back(ram_wr);
      if (jump_req) jumps <= jumps + 1;
   end
   task chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      checked++;
      if (got_v !== exp_v) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got_v, exp_v);
      end
   endtask : chk
   task results;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   initial begin
      rst = 1'b1; sw_reset = 1'b0; ale_pin = 1'b0; nmi_n_pin = 1'b0;
      bus_mode_select_0 = 1'b0; bus_mode_select_1 = 1'b0;
      bus_active_select_n = 1'b1;
      mismatches = 0; checked = 0;
      foreach (rows[i]) rows[i] = '{SBL_RAM_FIRST + 20'(i), 8'(i * 8'h29)};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk(mode, 1'b0);
      chk(txd, 1'b1);
      // second reset: strap high, bus mode pins flipped
      rst <= 1'b1; ale_pin <= 1'b1; bus_active_select_n <= 1'b0;
      bus_mode_select_0 <= 1'b1; bus_mode_select_1 <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      ale_pin <= 1'b0;
      chk(mode, 1'b1);
      u_sbl_host.glitch(4);
      repeat (4 * BIT) @(posedge clk);
      chk(baud_valid, 1'b0);
      fork
         u_sbl_host.send(8'h00, 1);
         u_sbl_host.recv(ack, ok);
      join
      chk(ok, 1'b1);
      chk(ack, SBL_ACK_BYTE);
      chk(baud_period, BIT);
      repeat (2 * BIT) @(posedge clk);
      foreach (rows[i]) u_sbl_host.send(rows[i].data, 1 + i % 2);
      n = 0;
      while ((got.size() < 32 || jumps == 0) && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n < 2000) begin
         chk(got.size(), 32);
         foreach (rows[i]) chk(got[i], rows[i]);
         chk(jumps, 1);
      end else mismatches++;
      // software reset exits even with the strap high
      chk(mode, 1'b1);
      ale_pin <= 1'b1; sw_reset <= 1'b1;
      repeat (3) @(posedge clk);
      chk(mode, 1'b0);
      results();
   end
endmodule : test_sbl_loader
